// ==== include/mfd_pkg.sv ====
// Shared constants, types and field layout for the flags datapath and dual data pointer unit
package mfd_pkg;

	// Special-function addresses
	localparam logic [7:0] MFD_CTRL_ADDR   = 8'ha7;
	localparam logic [7:0] MFD_PTR_LO_ADDR = 8'h82;
	localparam logic [7:0] MFD_PTR_HI_ADDR = 8'h83;

	// pointer_control_reg field positions and reset value
	localparam int         MFD_SWAP_BIT    = 6;
	localparam int         MFD_SHADOW_HI   = 5;
	localparam int         MFD_SHADOW_LO   = 4;
	localparam int         MFD_MAIN_HI     = 3;
	localparam int         MFD_MAIN_LO     = 2;
	localparam int         MFD_SEL_BIT     = 0;
	localparam logic [7:0] MFD_CTRL_RESET  = 8'h00;
	// Writable bits: 6..2 and 0; bits 7 and 1 are not implemented
	localparam logic [7:0] MFD_CTRL_WMASK  = 8'h7d;

	// Arithmetic constants
	localparam logic [3:0] MFD_NIBBLE_MAX  = 4'h9;
	localparam logic [9:0] MFD_DA_LOW_FIX  = 10'h006;
	localparam logic [9:0] MFD_DA_HIGH_FIX = 10'h060;
	localparam logic [9:0] MFD_BCD_MAX     = 10'h099;
	localparam logic [15:0] MFD_BYTE_MAX   = 16'h00ff;

	// Post-access modes of one pointer
	typedef enum logic [1:0] {
		MFD_STEP_CLASSIC = 2'b00,
		MFD_STEP_INC     = 2'b01,
		MFD_STEP_DEC     = 2'b10,
		MFD_STEP_TOGGLE  = 2'b11
	} mfd_step_t;

	// Operations served by the datapath
	typedef enum logic [2:0] {
		MFD_OP_NONE                    = 3'b000,
		MFD_OP_SUBTRACT_WITH_BORROW    = 3'b001,
		MFD_OP_PRODUCT_OP              = 3'b010,
		MFD_OP_QUOTIENT_OP             = 3'b011,
		MFD_OP_DECIMAL_ADJUST          = 3'b100,
		MFD_OP_ROTATE_RIGHT_THRU_CARRY = 3'b101,
		MFD_OP_ROTATE_LEFT_THRU_CARRY  = 3'b110,
		MFD_OP_COMPARE_BRANCH_UNEQUAL  = 3'b111
	} mfd_op_t;

	// Flags that travel with an operation
	typedef struct packed {
		logic carry;
		logic nibble_carry_flag;
		logic signed_wrap_flag;
	} mfd_flags_t;

	// Operation request from the core
	typedef struct packed {
		logic       valid;
		mfd_op_t    code;
		logic [7:0] acc;
		logic [7:0] second;
		logic [7:0] src;
		logic [7:0] dst;
		mfd_flags_t flags;
	} mfd_op_req_t;

	// Operation result back to the core
	typedef struct packed {
		logic       valid;
		logic [7:0] acc;
		logic [7:0] second;
		mfd_flags_t flags;
		logic       branch_taken;
	} mfd_op_res_t;

	// Special-function register access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mfd_sfr_req_t;

	// Memory move notice from the core
	typedef struct packed {
		logic valid;
		logic via_pointer;
	} mfd_move_t;

endpackage

// ==== logic/mfd_alu.sv ====
// Combinational result and flag logic for the arithmetic and rotate operations
`timescale 1ns/1ps
module mfd_alu
	import mfd_pkg::*;
(
	input  wire mfd_op_req_t req,
	output mfd_op_res_t      res
);

	// Borrow chain for subtract: separate widths expose borrows into bits 3, 6 and 7
	logic [4:0]  sub_lo;
	logic [7:0]  sub_mid;
	logic [8:0]  sub_full;
	logic [15:0] prod;
	logic        da_low;
	logic        da_high;
	logic [9:0]  da_sum;

	always_comb
	begin
		sub_lo   = {1'b0, req.acc[3:0]} - {1'b0, req.src[3:0]} - {4'h0, req.flags.carry};
		sub_mid  = {1'b0, req.acc[6:0]} - {1'b0, req.src[6:0]} - {7'h00, req.flags.carry};
		sub_full = {1'b0, req.acc} - {1'b0, req.src} - {8'h00, req.flags.carry};
		prod     = req.acc * req.second;
		da_low   = req.flags.nibble_carry_flag || (req.acc[3:0] > MFD_NIBBLE_MAX); // RULE9
		da_high  = req.flags.carry || da_low; // RULE10
		da_sum   = {2'b00, req.acc} + (da_low ? MFD_DA_LOW_FIX : 10'h000)
			+ (da_high ? MFD_DA_HIGH_FIX : 10'h000);
	end

	// Unlisted flags and operands fall through untouched
	always_comb
	begin
		res              = '0;
		res.valid        = req.valid;
		res.acc          = req.acc; // RULE25
		res.second       = req.second;
		res.flags        = req.flags;
		res.branch_taken = 1'b0;
		case (req.code)
			MFD_OP_SUBTRACT_WITH_BORROW:
			begin
				res.acc                     = sub_full[7:0]; // RULE1
				res.flags.carry             = sub_full[8]; // RULE2
				res.flags.signed_wrap_flag  = sub_mid[7] ^ sub_full[8]; // RULE3
				res.flags.nibble_carry_flag = sub_lo[4]; // RULE4
			end
			MFD_OP_PRODUCT_OP:
			begin
				res.acc                    = prod[7:0]; // RULE5
				res.second                 = prod[15:8];
				res.flags.carry            = 1'b0; // RULE6
				res.flags.signed_wrap_flag = prod > MFD_BYTE_MAX;
			end
			MFD_OP_QUOTIENT_OP:
			begin
				res.flags.carry = 1'b0; // RULE8
				// Zero divisor: operands are left as they were, which is one legal undefined result
				if (req.second == 8'h00)
					res.flags.signed_wrap_flag = 1'b1; // RULE8
				else
				begin
					res.acc                    = req.acc / req.second; // RULE7
					res.second                 = req.acc % req.second;
					res.flags.signed_wrap_flag = 1'b0;
				end
			end
			MFD_OP_DECIMAL_ADJUST:
			begin
				res.acc         = da_sum[7:0];
				res.flags.carry = da_sum > MFD_BCD_MAX; // RULE11
			end
			MFD_OP_ROTATE_RIGHT_THRU_CARRY:
			begin
				res.acc         = {req.flags.carry, req.acc[7:1]}; // RULE12
				res.flags.carry = req.acc[0];
			end
			MFD_OP_ROTATE_LEFT_THRU_CARRY:
			begin
				res.acc         = {req.acc[6:0], req.flags.carry}; // RULE13
				res.flags.carry = req.acc[7];
			end
			MFD_OP_COMPARE_BRANCH_UNEQUAL:
			begin
				res.branch_taken = req.src != req.dst; // RULE14
				res.flags.carry  = req.src > req.dst; // RULE15
			end
			default:
			begin
				res.branch_taken = 1'b0;
			end
		endcase
	end

endmodule // mfd_alu

// ==== logic/mfd_ptr_step.sv ====
// Post-access modification of one data pointer
`timescale 1ns/1ps
module mfd_ptr_step
	import mfd_pkg::*;
#(
	parameter int PTR_W = 16
)
(
	input  wire logic [1:0]       mode,
	input  wire logic [PTR_W-1:0] ptr,
	output logic      [PTR_W-1:0] ptr_next
);

	// Toggle mode keeps the upper bits, so at least two bits are needed
	if (PTR_W < 2)
	begin : g_width_check
		$error("mfd_ptr_step: PTR_W must be at least 2");
	end

	// Wraps at both ends, like the pointer arithmetic it replaces
	always_comb
	begin
		case (mfd_step_t'(mode))
			MFD_STEP_CLASSIC: ptr_next = ptr;
			MFD_STEP_INC:     ptr_next = ptr + PTR_W'(1); // RULE21
			MFD_STEP_DEC:     ptr_next = ptr - PTR_W'(1); // RULE21
			MFD_STEP_TOGGLE:  ptr_next = {ptr[PTR_W-1:1], ~ptr[0]}; // RULE21
			default:          ptr_next = ptr;
		endcase
	end

endmodule // mfd_ptr_step

// ==== logic/mfd_core.sv ====
// Flag datapath and dual data pointer unit of the microcontroller core
`timescale 1ns/1ps
// Operation
// RULE1 - Subtract with borrow: accumulator minus source minus carry into accumulator.
// RULE2 - Subtract: carry set on borrow into bit 7.
// RULE3 - Subtract: signed wrap set when exactly one of bits 6, 7 borrows.
// RULE4 - Subtract: nibble carry set on borrow into bit 3.
// RULE5 - Multiply unsigned; low byte to accumulator, high byte to second operand.
// RULE6 - Multiply clears carry; signed wrap set when product exceeds 255.
// RULE7 - Divide unsigned; quotient to accumulator, remainder to second operand.
// RULE8 - Divide clears carry; signed wrap set only for zero divisor.
// RULE9 - Decimal adjust adds 0x06 on nibble carry or low digit above nine.
// RULE10 - Then adds 0x60 on starting carry or when 0x06 was added.
// RULE11 - Decimal adjust sets carry when result exceeds 0x99.
// RULE12 - Rotate right through carry; carry takes old bit 0.
// RULE13 - Rotate left through carry; carry takes old bit 7.
// RULE14 - Compare: branch when source and destination differ, else fall through.
// RULE15 - Compare sets carry when source exceeds destination; reads no flag.
// RULE16 - Two 16-bit pointers, main and shadow, controlled at address 0xa7.
// RULE17 - Only pointer-addressed code or external moves modify the pointer.
// RULE18 - Control bit 6 enables automatic pointer swap after each move.
// RULE19 - Control bits 5:4 give shadow pointer mode; zero means unmodified.
// RULE20 - Control bit 7 ignores writes and reads zero.
// RULE21 - Mode 01 increments, 10 decrements, 11 toggles pointer bit 0.
// RULE22 - Control bits 3:2 give main pointer mode, same encoding.
// RULE23 - Control bit 0 selects main or shadow; it shows in pointer bytes.
// RULE24 - Auto swap inverts select after the active pointer's own step.
// RULE25 - Flags not listed for an operation keep their values.
module mfd_core
	import mfd_pkg::*;
#(
	parameter int PTR_W = 16
)
(
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire mfd_op_req_t  op_req,
	output mfd_op_res_t       op_res,
	input  wire mfd_sfr_req_t sfr_req,
	output logic [7:0]        sfr_rdata,
	output logic              sfr_hit,
	input  wire mfd_move_t    move,
	output logic [PTR_W-1:0]  data_pointer,
	output logic              pointer_select
);

	// Pointer bytes are addressed as two byte registers, so the width must be two bytes
	if (PTR_W != 16)
	begin : g_width_check
		$error("mfd_core: PTR_W must be 16");
	end

	// Whole module state
	typedef struct packed {
		logic [PTR_W-1:0] ptr_main;
		logic [PTR_W-1:0] ptr_shadow;
		logic [7:0]       ctrl;
		logic [PTR_W-1:0] active;
		logic [7:0]       rdata;
		mfd_op_res_t      res;
	} mfd_state_t;

	mfd_state_t       s_q;
	mfd_state_t       s_d;

	// Datapath results of the operation offered this cycle
	mfd_op_res_t      alu_res;

	// Pointer step values
	logic [1:0]       step_mode;
	logic [PTR_W-1:0] step_in;
	logic [PTR_W-1:0] step_out;

	// Decoded control fields of the current register value
	logic             auto_swap;
	logic             sel_shadow;
	logic [1:0]       main_mode;
	logic [1:0]       shadow_mode;
	logic             move_step;
	logic [PTR_W-1:0] cur_ptr;

	// Register decode results
	logic             hit_ctrl;
	logic             hit_lo;
	logic             hit_hi;

	// Read data mux as a function; the hit signals are decoded separately below
	function automatic logic [7:0] sfr_read(
		input logic [7:0]       addr,
		input logic [7:0]       ctrl,
		input logic [PTR_W-1:0] ptr
	);
		logic [7:0] val;
		val = 8'h00;
		case (addr)
			MFD_CTRL_ADDR:   val = ctrl & MFD_CTRL_WMASK; // RULE20
			MFD_PTR_LO_ADDR: val = ptr[7:0]; // RULE23
			MFD_PTR_HI_ADDR: val = ptr[15:8]; // RULE23
			default:         val = 8'h00;
		endcase
		return val;
	endfunction

	mfd_alu u_alu (
		.req (op_req),
		.res (alu_res)
	);

	mfd_ptr_step #(
		.PTR_W (PTR_W)
	) u_step (
		.mode     (step_mode),
		.ptr      (step_in),
		.ptr_next (step_out)
	);

	// Control field decode
	always_comb
	begin
		auto_swap   = s_q.ctrl[MFD_SWAP_BIT]; // RULE18
		sel_shadow  = s_q.ctrl[MFD_SEL_BIT]; // RULE23
		shadow_mode = {s_q.ctrl[MFD_SHADOW_HI], s_q.ctrl[MFD_SHADOW_LO]}; // RULE19
		main_mode   = {s_q.ctrl[MFD_MAIN_HI], s_q.ctrl[MFD_MAIN_LO]}; // RULE22
		cur_ptr     = sel_shadow ? s_q.ptr_shadow : s_q.ptr_main; // RULE16
	end

	// Only the active pointer steps, and only on pointer-addressed moves
	always_comb
	begin
		move_step = move.valid && move.via_pointer; // RULE17
		step_mode = sel_shadow ? shadow_mode : main_mode;
		step_in   = cur_ptr;
	end

	// Register decode
	always_comb
	begin
		hit_ctrl = sfr_req.addr == MFD_CTRL_ADDR; // RULE16
		hit_lo   = sfr_req.addr == MFD_PTR_LO_ADDR;
		hit_hi   = sfr_req.addr == MFD_PTR_HI_ADDR;
	end

	// Next state
	// Order matters: the move step is applied first, then a register write in the
	// same cycle overrides it, since software writes are meant to win.
	always_comb
	begin
		s_d     = s_q;
		s_d.res = alu_res;

		// Step the active pointer, then swap if enabled
		if (move_step)
		begin
			if (sel_shadow)
				s_d.ptr_shadow = step_out; // RULE19
			else
				s_d.ptr_main = step_out; // RULE22
		end
		// Swap follows any code or external move, after the step above
		if (move.valid && auto_swap)
			s_d.ctrl[MFD_SEL_BIT] = ~sel_shadow; // RULE24

		// Software writes
		if (sfr_req.wr)
		begin
			if (hit_ctrl)
				s_d.ctrl = sfr_req.wdata & MFD_CTRL_WMASK; // RULE20
			if (hit_lo)
			begin
				if (sel_shadow)
					s_d.ptr_shadow[7:0] = sfr_req.wdata; // RULE23
				else
					s_d.ptr_main[7:0] = sfr_req.wdata;
			end
			if (hit_hi)
			begin
				if (sel_shadow)
					s_d.ptr_shadow[15:8] = sfr_req.wdata; // RULE23
				else
					s_d.ptr_main[15:8] = sfr_req.wdata;
			end
		end

		// Registered copy of whichever pointer is active after this edge
		s_d.active = s_d.ctrl[MFD_SEL_BIT] ? s_d.ptr_shadow : s_d.ptr_main; // RULE23

		// Read data captured on a read strobe and held until the next one
		if (sfr_req.rd)
			s_d.rdata = sfr_read(sfr_req.addr, s_q.ctrl, cur_ptr);
	end

	// State register
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			s_q      <= '0;
			s_q.ctrl <= MFD_CTRL_RESET; // RULE18
		end
		else
			s_q <= s_d;
	end

	// Outputs
	// Hit is a combinational handshake so the core can tell its own registers apart
	assign op_res         = s_q.res;
	assign sfr_rdata      = s_q.rdata;
	assign sfr_hit        = hit_ctrl || hit_lo || hit_hi;
	assign data_pointer   = s_q.active;
	assign pointer_select = s_q.ctrl[MFD_SEL_BIT];

endmodule // mfd_core

// ==== test/mfd_core_properties.sv ====
// Concurrent property checker for the flag datapath and dual pointer unit
`timescale 1ns/1ps
module mfd_core_properties
	import mfd_pkg::*;
#(
	parameter int PTR_W = 16
)
(
	input wire logic             sys_clk,
	input wire logic             rst_b,
	input wire mfd_op_req_t      op_req,
	input wire mfd_op_res_t      op_res,
	input wire mfd_sfr_req_t     sfr_req,
	input wire mfd_move_t        move,
	input wire logic [PTR_W-1:0] data_pointer,
	input wire logic             pointer_select
);
	// Everything lives in the core clock domain
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// Nine-bit difference carries the borrow out of bit 7 in its top bit
	chk_sub_result: assert property (op_req.valid && op_req.code == MFD_OP_SUBTRACT_WITH_BORROW |=>
		{op_res.flags.carry, op_res.acc} == ({1'b0, $past(op_req.acc)} - {1'b0, $past(op_req.src)}
		- {8'h00, $past(op_req.flags.carry)}))
		else $error("subtract result wrong");
	// Wrap flag is tied to a nonzero high byte, the cheapest form of above 255
	chk_mul_result: assert property (op_req.valid && op_req.code == MFD_OP_PRODUCT_OP |=>
		{op_res.second, op_res.acc} == ({8'h00, $past(op_req.acc)} * {8'h00, $past(op_req.second)})
		&& !op_res.flags.carry
		&& op_res.flags.signed_wrap_flag == (op_res.second != 8'h00)) else $error("multiply result wrong");
	chk_div_result: assert property (op_req.valid && op_req.code == MFD_OP_QUOTIENT_OP && op_req.second != 8'h00 |=>
		op_res.acc == $past(op_req.acc) / $past(op_req.second) && op_res.second == $past(op_req.acc) % $past(op_req.second)
		&& !op_res.flags.carry && !op_res.flags.signed_wrap_flag) else $error("divide result wrong");
	chk_rrc_result: assert property (op_req.valid && op_req.code == MFD_OP_ROTATE_RIGHT_THRU_CARRY |=>
		op_res.acc == {$past(op_req.flags.carry), $past(op_req.acc[7:1])} && op_res.flags.carry == $past(op_req.acc[0])
		&& op_res.flags[1:0] == $past(op_req.flags[1:0])) else $error("rotate right wrong");
	chk_rlc_result: assert property (op_req.valid && op_req.code == MFD_OP_ROTATE_LEFT_THRU_CARRY |=>
		op_res.acc == {$past(op_req.acc[6:0]), $past(op_req.flags.carry)} && op_res.flags.carry == $past(op_req.acc[7]))
		else $error("rotate left wrong");
	chk_cmp_branch: assert property (op_req.valid && op_req.code == MFD_OP_COMPARE_BRANCH_UNEQUAL |=>
		op_res.flags.carry == ($past(op_req.src) > $past(op_req.dst))
		&& op_res.branch_taken == ($past(op_req.src) != $past(op_req.dst))) else $error("compare wrong");
	chk_sel_write: assert property (sfr_req.wr && sfr_req.addr == MFD_CTRL_ADDR |=>
		pointer_select == $past(sfr_req.wdata[0])) else $error("select bit not written");
	chk_ptr_idle: assert property (!move.valid && !sfr_req.wr |=>
		$stable(data_pointer) && $stable(pointer_select)) else $error("pointer moved without cause");
endmodule // mfd_core_properties

bind mfd_core mfd_core_properties #(.PTR_W(PTR_W)) chk_u (.sys_clk(sys_clk), .rst_b(rst_b), .op_req(op_req),
	.op_res(op_res), .sfr_req(sfr_req), .move(move), .data_pointer(data_pointer), .pointer_select(pointer_select));

// ==== test/mfd_core_tb_top.sv ====
// Self-checking bench for the flag datapath and dual pointer unit
`timescale 1ns/1ps
module mfd_core_tb_top import mfd_pkg::*;;
	logic         sys_clk = 1'b0;
	logic         rst_b = 1'b0;
	mfd_op_req_t  op_req = '0;
	mfd_op_res_t  op_res;
	mfd_sfr_req_t sfr_req = '0;
	logic [7:0]   sfr_rdata;
	logic         sfr_hit;
	mfd_move_t    move = '0;
	logic [15:0]  data_pointer;
	logic         pointer_select;
	int           n_errors = 0;
	int           check_count = 0;

	// 10 MHz core clock
	always #50 sys_clk = ~sys_clk;

	mfd_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .op_req(op_req), .op_res(op_res), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .move(move), .data_pointer(data_pointer),
		.pointer_select(pointer_select));

	// Case equality so an unknown never passes
	task automatic check(logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// One operation; its result stands for one cycle only, so look right after the taking edge
	task automatic op(mfd_op_t c, logic [7:0] a, b, s, d, logic [2:0] f, logic [7:0] ea, eb, logic [2:0] ef, logic br);
		@(posedge sys_clk) op_req <= '{1'b1, c, a, b, s, d, f};
		@(posedge sys_clk) op_req.valid <= 1'b0;
		#1 check({op_res.acc, op_res.second}, {ea, eb});
		check({11'h000, op_res.valid, op_res.flags, op_res.branch_taken}, {11'h000, 1'b1, ef, br});
	endtask

	// Register access: w high writes, low reads
	task automatic sfr(logic w, logic [7:0] a, d);
		@(posedge sys_clk) sfr_req <= '{w, !w, a, d};
		@(posedge sys_clk) sfr_req <= '0;
		#1;
	endtask

	// Read with the combinational hit looked at while the request stands
	task automatic rd(logic [7:0] a, e, logic eh);
		@(posedge sys_clk) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
		#1 check({15'h0000, sfr_hit}, {15'h0000, eh});
		@(posedge sys_clk) sfr_req <= '0;
		#1 check({8'h00, sfr_rdata}, {8'h00, e});
	endtask

	// One code or external move, then the active pointer and select are compared
	task automatic mv(logic v, logic [15:0] edp, logic esel);
		@(posedge sys_clk) move <= '{1'b1, v};
		@(posedge sys_clk) move <= '0;
		#1 check(data_pointer, edp);
		check({15'h0000, pointer_select}, {15'h0000, esel});
	endtask

	// Main sequence; flag vectors are {carry, nibble, wrap}
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		op(MFD_OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h00, 8'h01, 8'h00, 3'b000, 8'h7f, 8'h00, 3'b011, 1'b0);
		op(MFD_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 8'h00, 8'h00, 3'b100, 8'hff, 8'h00, 3'b110, 1'b0);
		op(MFD_OP_PRODUCT_OP, 8'h20, 8'h10, 8'h00, 8'h00, 3'b100, 8'h00, 8'h02, 3'b001, 1'b0);
		op(MFD_OP_PRODUCT_OP, 8'h0f, 8'h11, 8'h00, 8'h00, 3'b111, 8'hff, 8'h00, 3'b010, 1'b0);
		op(MFD_OP_QUOTIENT_OP, 8'hfb, 8'h10, 8'h00, 8'h00, 3'b101, 8'h0f, 8'h0b, 3'b000, 1'b0);
		op(MFD_OP_QUOTIENT_OP, 8'h35, 8'h00, 8'h00, 8'h00, 3'b100, 8'h35, 8'h00, 3'b001, 1'b0);
		op(MFD_OP_DECIMAL_ADJUST, 8'h9a, 8'h00, 8'h00, 8'h00, 3'b000, 8'h00, 8'h00, 3'b100, 1'b0);
		op(MFD_OP_DECIMAL_ADJUST, 8'h12, 8'h00, 8'h00, 8'h00, 3'b010, 8'h78, 8'h00, 3'b010, 1'b0);
		op(MFD_OP_DECIMAL_ADJUST, 8'h25, 8'h00, 8'h00, 8'h00, 3'b100, 8'h85, 8'h00, 3'b000, 1'b0);
		op(MFD_OP_ROTATE_RIGHT_THRU_CARRY, 8'h01, 8'h00, 8'h00, 8'h00, 3'b011, 8'h00, 8'h00, 3'b111, 1'b0);
		op(MFD_OP_ROTATE_LEFT_THRU_CARRY, 8'h80, 8'h00, 8'h00, 8'h00, 3'b100, 8'h01, 8'h00, 3'b100, 1'b0);
		op(MFD_OP_COMPARE_BRANCH_UNEQUAL, 8'h00, 8'h00, 8'h05, 8'h03, 3'b000, 8'h00, 8'h00, 3'b100, 1'b1);
		op(MFD_OP_COMPARE_BRANCH_UNEQUAL, 8'h00, 8'h00, 8'h03, 8'h05, 3'b111, 8'h00, 8'h00, 3'b011, 1'b1);
		op(MFD_OP_COMPARE_BRANCH_UNEQUAL, 8'h00, 8'h00, 8'h07, 8'h07, 3'b100, 8'h00, 8'h00, 3'b000, 1'b0);
		rd(MFD_CTRL_ADDR, 8'h00, 1'b1);
		sfr(1'b1, MFD_CTRL_ADDR, 8'hff);
		rd(MFD_CTRL_ADDR, 8'h7d, 1'b1);
		rd(8'h81, 8'h00, 1'b0);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h01);
		sfr(1'b1, MFD_PTR_HI_ADDR, 8'hd0);
		sfr(1'b1, MFD_PTR_LO_ADDR, 8'h00);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h55);
		mv(1'b1, 16'h0000, 1'b0);
		mv(1'b1, 16'hd001, 1'b1);
		mv(1'b0, 16'h0001, 1'b0);
		rd(MFD_PTR_LO_ADDR, 8'h01, 1'b1);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h08);
		mv(1'b1, 16'h0000, 1'b0);
		mv(1'b1, 16'hffff, 1'b0);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h0c);
		mv(1'b1, 16'hfffe, 1'b0);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h21);
		mv(1'b1, 16'hd000, 1'b1);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h31);
		mv(1'b1, 16'hd001, 1'b1);
		sfr(1'b1, MFD_CTRL_ADDR, 8'h01);
		mv(1'b1, 16'hd001, 1'b1);
		rd(MFD_PTR_HI_ADDR, 8'hd0, 1'b1);
		print_verdict();
	end

	// Watchdog: the run needs about eighty cycles, this allows two thousand
	initial
	begin
		#200000;
		n_errors++;
		print_verdict();
	end
endmodule // mfd_core_tb_top
